// *** iap_pkg.sv ***
// What this block does
// [RULE1] software selects write-enable mode code 110
// [RULE2] software sets unlock enable, same write allowed
// [RULE3] six key bytes compared in fixed order
// [RULE4] unlock starts roughly 300 us timeout window
// [RULE5] timeout or wrong byte aborts, clears enable
// [RULE6] correct key enables writes, sets flag
// [RULE7] clearing flag blocks writes until next unlock
// [RULE8] software erases page only after unlock
// [RULE9] erase page from high address plus top bits
// [RULE10] core stalls while write or read runs
// [RULE11] timer runs only during active unlock procedure
// [RULE12] mode codes: program, erase, read, reserved
// [RULE13] software writing one to flag does nothing
// [RULE14] data0 high write loads buffer, bumps address
// [RULE15] hardware clears write initiate when done
package iap_pkg;
	localparam logic [6:0] ADDR_CTRL = 7'h43;
	localparam logic [6:0] ADDR_RESETPAT = 7'h44;
	localparam logic [6:0] ADDR_BUFCLR = 7'h45;
	localparam logic [6:0] ADDR_ADDRLO = 7'h74;
	localparam logic [6:0] ADDR_ADDRHI = 7'h75;
	localparam logic [6:0] ADDR_D0L = 7'h76;
	localparam logic [6:0] ADDR_D0H = 7'h77;
	localparam logic [6:0] ADDR_D1L = 7'h78;
	localparam logic [6:0] ADDR_D1H = 7'h79;
	localparam logic [6:0] ADDR_D2L = 7'h7A;
	localparam logic [6:0] ADDR_D2H = 7'h7B;
	localparam logic [6:0] ADDR_D3L = 7'h7C;
	localparam logic [6:0] ADDR_D3H = 7'h7D;
	localparam int BIT_FLAG = 7;
	localparam int BIT_MODE = 4;
	localparam int BIT_UNLOCK = 3;
	localparam int BIT_WINIT = 2;
	localparam int BIT_RDEN = 1;
	localparam int BIT_RINIT = 0;
	localparam logic [2:0] MODE_PROGRAM = 3'h0;
	localparam logic [2:0] MODE_ERASE = 3'h1;
	localparam logic [2:0] MODE_READ = 3'h3;
	localparam logic [2:0] MODE_UNLOCK = 3'h6;
	localparam logic [7:0] RESET_VAL = 8'h00;
	localparam logic [7:0] KEY0 = 8'h00;
	localparam logic [7:0] KEY1 = 8'h04;
	localparam logic [7:0] KEY2 = 8'h0D;
	localparam logic [7:0] KEY3 = 8'h09;
	localparam logic [7:0] KEY4 = 8'hC3;
	localparam logic [7:0] KEY5 = 8'h40;
	localparam int TIMEOUT_US = 300;
	localparam int CLK_MHZ = 100;
	localparam int OSC_KHZ = 32;
	localparam int OSC_DIV = (CLK_MHZ * 1000) / OSC_KHZ;
	localparam int TIMEOUT_TICKS = (TIMEOUT_US * OSC_KHZ) / 1000;
	localparam int OP_CYCLES = 16;
	typedef struct packed {
		logic wr;
		logic rd;
		logic [6:0] addr;
		logic [7:0] wdata;
	} bus_s;
	typedef struct packed {
		logic start;
		logic erase;
		logic read;
		logic [15:0] addr;
	} flash_op_s;
endpackage

// *** slow_tick.sv ***
`timescale 1ns/1ps
module slow_tick #(
	parameter int DIV = iap_pkg::OSC_DIV
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// one-cycle enable out
	output logic tick
);
	if (DIV < 2) begin : g_divCheck
		$error("slow_tick: DIV must be at least 2");
	end
	logic [$clog2(DIV)-1:0] cnt;
	wire wrapNow = (cnt == ($clog2(DIV))'(DIV - 1));
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			cnt <= '0;
			tick <= 1'b0;
		end else begin
			cnt <= wrapNow ? '0 : cnt + 1'b1;
			tick <= wrapNow;
		end
	end
endmodule // slow_tick

// *** iap_flash_write_unlock_erase.sv ***
`timescale 1ns/1ps
module iap_flash_write_unlock_erase #(
	parameter int ADDR_W = 16,
	parameter int PAGE_WORDS = 128,
	parameter int TIMEOUT = iap_pkg::TIMEOUT_TICKS,
	parameter int OP_LEN = iap_pkg::OP_CYCLES
) (
	// clock and reset
	input wire logic clk,
	input wire logic rstn,
	// data memory access from the core
	input wire iap_pkg::bus_s bus,
	output logic [7:0] rdata,
	// flash side
	output iap_pkg::flash_op_s flashOp,
	output logic [15:0] bufWord,
	output logic bufLoad,
	input wire logic opDone,
	// core control
	output logic coreStall,
	output logic writeEnabled
);
	localparam int PBITS = $clog2(PAGE_WORDS);
	if (PAGE_WORDS != 32 && PAGE_WORDS != 64 && PAGE_WORDS != 128) begin : g_pageCheck
		$error("PAGE_WORDS must be 32, 64 or 128");
	end
	if (ADDR_W < 13 || ADDR_W > 16) begin : g_addrCheck
		$error("ADDR_W must be 13..16");
	end
	if (TIMEOUT < 1 || TIMEOUT > 255) begin : g_timeoutCheck
		$error("TIMEOUT out of range");
	end
	if (OP_LEN < 1) begin : g_opLenCheck
		$error("OP_LEN must be at least 1");
	end

	typedef enum logic [1:0] {IDLE = 2'b00, KEYWAIT = 2'b01, BUSY = 2'b11} state_e;
	state_e state;
	logic [7:0] ctrl, addrLo, addrHi, d0l, d1l, d1h, d2l, d2h, d3l, d3h;
	logic [2:0] keyIdx;
	logic [7:0] toCnt;
	logic [$clog2(OP_LEN+1)-1:0] opCnt;
	logic tick;

	slow_tick u_tick (.clk(clk), .rstn(rstn), .tick(tick));

	wire wrCtrl = bus.wr && bus.addr == iap_pkg::ADDR_CTRL;
	wire wrD0H = bus.wr && bus.addr == iap_pkg::ADDR_D0H;
	wire [2:0] newMode = bus.wdata[iap_pkg::BIT_MODE +: 3];
	wire unlockReq = wrCtrl && bus.wdata[iap_pkg::BIT_UNLOCK]
		&& newMode == iap_pkg::MODE_UNLOCK; // [RULE1] [RULE2] [RULE11]
	wire keyWr = bus.wr && bus.addr >= iap_pkg::ADDR_D1L && bus.addr <= iap_pkg::ADDR_D3H;
	wire [2:0] keyPos = 3'(bus.addr - iap_pkg::ADDR_D1L);
	logic [7:0] keyExp;
	always_comb begin
		unique case (keyIdx)
			3'd0: keyExp = iap_pkg::KEY0;
			3'd1: keyExp = iap_pkg::KEY1;
			3'd2: keyExp = iap_pkg::KEY2;
			3'd3: keyExp = iap_pkg::KEY3;
			3'd4: keyExp = iap_pkg::KEY4;
			default: keyExp = iap_pkg::KEY5;
		endcase
	end
	// an out-of-order byte counts as wrong
	wire keyOk = keyPos == keyIdx && bus.wdata == keyExp; // [RULE3]
	wire keyBad = state == KEYWAIT && keyWr && !keyOk; // [RULE5]
	wire keyLast = state == KEYWAIT && keyWr && keyOk && keyIdx == 3'd5; // [RULE6]
	// first tick may land at once: window spans TIMEOUT-1 to TIMEOUT ticks
	wire timedOut = state == KEYWAIT && tick && toCnt == 8'(TIMEOUT - 1); // [RULE4] [RULE5]
	wire sw1Win = wrCtrl && bus.wdata[iap_pkg::BIT_WINIT];
	wire sw1Rin = wrCtrl && bus.wdata[iap_pkg::BIT_RINIT];
	// writes and erases need the unlock; reads never do
	wire opWrite = sw1Win && writeEnabled
		&& (newMode == iap_pkg::MODE_PROGRAM || newMode == iap_pkg::MODE_ERASE); // [RULE7] [RULE12]
	wire opRead = sw1Rin && bus.wdata[iap_pkg::BIT_RDEN]
		&& newMode == iap_pkg::MODE_READ; // [RULE12]
	wire opStart = state == IDLE && (opWrite || opRead);
	wire opEnd = state == BUSY && (opDone || opCnt == '0);
	wire [15:0] fullAddr = 16'({addrHi, addrLo});
	wire [15:0] addrMask = 16'((32'h1 << ADDR_W) - 1);
	wire [15:0] pageMask = 16'((32'h1 << PBITS) - 1);
	wire [15:0] pageAddr = fullAddr & addrMask & ~pageMask; // [RULE9]

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			state <= IDLE;
			keyIdx <= '0;
			toCnt <= '0;
			opCnt <= '0;
		end else begin
			unique case (state)
				IDLE: begin
					keyIdx <= '0;
					toCnt <= '0;
					if (unlockReq) state <= KEYWAIT; // [RULE11]
					else if (opStart) begin
						state <= BUSY;
						opCnt <= ($bits(opCnt))'(OP_LEN);
					end
				end
				KEYWAIT: begin
					if (keyBad || keyLast || timedOut) state <= IDLE; // [RULE11]
					if (keyWr && keyOk) keyIdx <= keyIdx + 3'd1;
					if (tick) toCnt <= toCnt + 8'd1; // [RULE4]
				end
				BUSY: begin
					opCnt <= opCnt - 1'b1;
					if (opEnd) state <= IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			ctrl <= iap_pkg::RESET_VAL;
		end else begin
			if (wrCtrl) begin
				ctrl[6:0] <= bus.wdata[6:0];
				// only a clear reaches the flag from software
				if (!bus.wdata[iap_pkg::BIT_FLAG]) ctrl[iap_pkg::BIT_FLAG] <= 1'b0; // [RULE13] [RULE7]
				if (!opStart) begin
					ctrl[iap_pkg::BIT_WINIT] <= 1'b0;
					ctrl[iap_pkg::BIT_RINIT] <= 1'b0;
				end
			end
			if (keyBad || timedOut) ctrl[iap_pkg::BIT_UNLOCK] <= 1'b0; // [RULE5]
			if (keyLast) begin
				ctrl[iap_pkg::BIT_UNLOCK] <= 1'b0; // [RULE6]
				ctrl[iap_pkg::BIT_FLAG] <= 1'b1; // [RULE6]
			end
			if (opEnd) begin
				ctrl[iap_pkg::BIT_WINIT] <= 1'b0; // [RULE15]
				ctrl[iap_pkg::BIT_RINIT] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			{addrLo, addrHi, d0l, d1l, d1h, d2l, d2h, d3l, d3h} <= '0;
		end else if (bus.wr) begin
			if (bus.addr == iap_pkg::ADDR_ADDRLO) addrLo <= bus.wdata;
			if (bus.addr == iap_pkg::ADDR_ADDRHI) addrHi <= bus.wdata & addrMask[15:8];
			if (bus.addr == iap_pkg::ADDR_D0L) d0l <= bus.wdata;
			if (bus.addr == iap_pkg::ADDR_D1L) d1l <= bus.wdata;
			if (bus.addr == iap_pkg::ADDR_D1H) d1h <= bus.wdata;
			if (bus.addr == iap_pkg::ADDR_D2L) d2l <= bus.wdata;
			if (bus.addr == iap_pkg::ADDR_D2H) d2h <= bus.wdata;
			if (bus.addr == iap_pkg::ADDR_D3L) d3l <= bus.wdata;
			if (bus.addr == iap_pkg::ADDR_D3H) d3h <= bus.wdata;
			if (wrD0H) {addrHi, addrLo} <= (fullAddr + 16'd1) & addrMask; // [RULE14]
		end
	end

	logic [7:0] next_rdata;
	always_comb begin
		unique case (bus.addr)
			iap_pkg::ADDR_CTRL: next_rdata = ctrl;
			iap_pkg::ADDR_ADDRLO: next_rdata = addrLo;
			iap_pkg::ADDR_ADDRHI: next_rdata = addrHi;
			iap_pkg::ADDR_D0L: next_rdata = d0l;
			iap_pkg::ADDR_D1L: next_rdata = d1l;
			iap_pkg::ADDR_D1H: next_rdata = d1h;
			iap_pkg::ADDR_D2L: next_rdata = d2l;
			iap_pkg::ADDR_D2H: next_rdata = d2h;
			iap_pkg::ADDR_D3L: next_rdata = d3l;
			iap_pkg::ADDR_D3H: next_rdata = d3h;
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			rdata <= 8'h00;
			flashOp <= '0;
			bufWord <= 16'h0000;
			bufLoad <= 1'b0;
			coreStall <= 1'b0;
			writeEnabled <= 1'b0;
		end else begin
			rdata <= bus.rd ? next_rdata : 8'h00;
			flashOp.start <= opStart;
			flashOp.erase <= opStart && newMode == iap_pkg::MODE_ERASE;
			flashOp.read <= opStart && opRead;
			flashOp.addr <= (newMode == iap_pkg::MODE_ERASE) ? pageAddr : fullAddr; // [RULE9]
			bufLoad <= wrD0H; // [RULE14]
			if (wrD0H) bufWord <= {bus.wdata, d0l};
			coreStall <= (opStart || state == BUSY) && !opEnd; // [RULE10]
			writeEnabled <= (keyLast || ctrl[iap_pkg::BIT_FLAG])
				&& !(wrCtrl && !bus.wdata[iap_pkg::BIT_FLAG] && !keyLast);
		end
	end

	AST_STALL: assert property (@(posedge clk) disable iff (!rstn) // [RULE10]
		opStart |=> coreStall) else $error("no stall on op start");
	AST_UNLOCK_OK: assert property (@(posedge clk) disable iff (!rstn) // [RULE6]
		keyLast |=> ctrl[7] && !ctrl[3] ##1 writeEnabled) else $error("unlock failed");
	AST_ABORT: assert property (@(posedge clk) disable iff (!rstn) // [RULE5]
		keyBad |=> !ctrl[3] && state == IDLE) else $error("bad key not aborted");
	AST_TIMEOUT: assert property (@(posedge clk) disable iff (!rstn) // [RULE4] [RULE5]
		timedOut |=> !ctrl[3] && state == IDLE) else $error("timeout not aborted");
	AST_NOWRITE: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
		opStart && !opRead |-> ctrl[7]) else $error("write while locked");
	AST_RELOCK: assert property (@(posedge clk) disable iff (!rstn) // [RULE7]
		wrCtrl && !bus.wdata[7] |=> !ctrl[7] && !writeEnabled) else $error("flag kept");
	AST_SWSET: assert property (@(posedge clk) disable iff (!rstn) // [RULE13]
		wrCtrl && !keyLast && !ctrl[7] |=> !ctrl[7]) else $error("sw set flag");
	AST_BUMP: assert property (@(posedge clk) disable iff (!rstn) // [RULE14]
		wrD0H && fullAddr != addrMask |=> {addrHi, addrLo} == $past(fullAddr) + 16'h0001)
		else $error("address not bumped");
	AST_WINIT_CLR: assert property (@(posedge clk) disable iff (!rstn) // [RULE15]
		opEnd |=> !ctrl[2] && !ctrl[0]) else $error("initiate not cleared");
	AST_TIMER_IDLE: assert property (@(posedge clk) disable iff (!rstn) // [RULE11]
		state != KEYWAIT |=> toCnt == 8'h00 || state == KEYWAIT) else $error("timer ran");
	AST_PAGE: assert property (@(posedge clk) disable iff (!rstn) // [RULE9]
		flashOp.erase |-> (flashOp.addr & pageMask) == 16'h0000)
		else $error("page bits set");
	COV_UNLOCK: cover property (@(posedge clk) disable iff (!rstn) keyLast);
	COV_TIMEOUT: cover property (@(posedge clk) disable iff (!rstn) timedOut);
	COV_BADKEY: cover property (@(posedge clk) disable iff (!rstn) keyBad);
	COV_ERASE: cover property (@(posedge clk) disable iff (!rstn) flashOp.erase);
	COV_READ: cover property (@(posedge clk) disable iff (!rstn) flashOp.read);
endmodule // iap_flash_write_unlock_erase

// *** testbench.sv ***
`timescale 1ns/1ps
module testbench;
	localparam int OPL = 4;
	logic clk;
	logic rstn;
	logic opDone;
	logic bufLoad;
	logic coreStall;
	logic writeEnabled;
	logic [7:0] rdata;
	logic [7:0] v;
	logic [15:0] bufWord;
	iap_pkg::bus_s bus;
	iap_pkg::flash_op_s flashOp;
	int mismatches = 0;
	int samples_checked = 0;

	// short timeout and op length keep the run brief
	iap_flash_write_unlock_erase #(.TIMEOUT(2), .OP_LEN(OPL)) iap_flash_write_unlock_erase_inst (
		.clk(clk), .rstn(rstn), .bus(bus), .rdata(rdata), .flashOp(flashOp),
		.bufWord(bufWord), .bufLoad(bufLoad), .opDone(opDone),
		.coreStall(coreStall), .writeEnabled(writeEnabled));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e) begin
			mismatches++;
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
		@(posedge clk);
		bus <= '0;
	endtask

	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(posedge clk);
		bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(posedge clk);
		bus <= '0;
		#1 d = rdata;
	endtask

	// six key bytes in offset order, third one replaceable
	task automatic keys(input logic [7:0] k2);
		logic [7:0] k[6] = '{iap_pkg::KEY0, iap_pkg::KEY1, k2,
			iap_pkg::KEY3, iap_pkg::KEY4, iap_pkg::KEY5};
		for (int i = 0; i < 6; i++) begin
			wr(7'(iap_pkg::ADDR_D1L + i), k[i]);
		end
	endtask

	// one control write, then watch start, stall and completion
	task automatic op(input logic [7:0] c, input logic go, input logic [15:0] a,
		input logic er, input logic rdop);
		int s = 0;
		int st = 0;
		logic dn = 1'b0;
		wr(iap_pkg::ADDR_CTRL, c);
		for (int n = 0; n < 14; n++) begin
			if (n > 0) begin
				@(posedge clk);
				opDone <= dn;
			end
			#1;
			if (flashOp.start === 1'b1) begin
				s = 1;
				dn = rdop;
				chk("erase kind", er, flashOp.erase);
				chk("read kind", rdop, flashOp.read);
				chk("op address", a, flashOp.addr);
			end
			if (coreStall === 1'b1) st++;
		end
		@(posedge clk);
		opDone <= 1'b0;
		chk("op started", go, 16'(s));
		chk("stall span", go, st > 0 && st <= OPL + 2);
		rd(iap_pkg::ADDR_CTRL, v);
		chk("initiate cleared", 2'b00, {v[2], v[0]});
	endtask

	task automatic t_regs;
		logic [6:0] al[4] = '{iap_pkg::ADDR_D2H, iap_pkg::ADDR_D3L,
			iap_pkg::ADDR_D3H, iap_pkg::ADDR_CTRL};
		for (int i = 0; i < 4; i++) begin
			rd(al[i], v);
			chk("reset value", 8'h00, v);
		end
		for (int i = 0; i < 3; i++) begin
			wr(al[i], 8'(8'h5A + i));
			rd(al[i], v);
			chk("data reg", 8'(8'h5A + i), v);
		end
		wr(7'h7E, 8'hFF);
		rd(7'h7E, v);
		chk("unmapped", 8'h00, v);
		$display("register test done");
	endtask

	task automatic t_locked;
		wr(iap_pkg::ADDR_CTRL, 8'h80);
		rd(iap_pkg::ADDR_CTRL, v);
		chk("flag by software", 8'h00, v);
		chk("write enabled", 1'b0, writeEnabled);
		op(8'h14, 1'b0, 16'h0000, 1'b1, 1'b0);
		$display("locked test done");
	endtask

	task automatic t_unlockFail;
		wr(iap_pkg::ADDR_CTRL, 8'h68);
		repeat (7000) @(posedge clk);
		rd(iap_pkg::ADDR_CTRL, v);
		chk("timeout abort", 2'b00, {v[7], v[3]});
		keys(iap_pkg::KEY2);
		rd(iap_pkg::ADDR_CTRL, v);
		chk("key without procedure", 1'b0, v[7]);
		wr(iap_pkg::ADDR_CTRL, 8'h68);
		keys(8'h0E);
		rd(iap_pkg::ADDR_CTRL, v);
		chk("wrong key abort", 2'b00, {v[7], v[3]});
		$display("failed unlock test done");
	endtask

	task automatic t_unlock;
		wr(iap_pkg::ADDR_CTRL, 8'h68);
		rd(iap_pkg::ADDR_CTRL, v);
		chk("procedure running", 1'b1, v[3]);
		keys(iap_pkg::KEY2);
		rd(iap_pkg::ADDR_CTRL, v);
		chk("unlocked", 2'b10, {v[7], v[3]});
		chk("write enabled", 1'b1, writeEnabled);
		$display("unlock test done");
	endtask

	task automatic t_ops;
		int s = 0;
		wr(iap_pkg::ADDR_ADDRHI, 8'h12);
		wr(iap_pkg::ADDR_ADDRLO, 8'hFF);
		op(8'h94, 1'b1, 16'h1280, 1'b1, 1'b0);
		op(8'h84, 1'b1, 16'h12FF, 1'b0, 1'b0);
		op(8'hB3, 1'b1, 16'h12FF, 1'b0, 1'b1);
		wr(iap_pkg::ADDR_ADDRLO, 8'h10);
		wr(iap_pkg::ADDR_D0L, 8'h34);
		wr(iap_pkg::ADDR_D0H, 8'h12);
		for (int n = 0; n < 3; n++) begin
			if (n > 0) @(posedge clk);
			#1;
			if (bufLoad === 1'b1) begin
				s = 1;
				chk("buffer word", 16'h1234, bufWord);
			end
		end
		chk("buffer load", 1'b1, 16'(s));
		rd(iap_pkg::ADDR_ADDRLO, v);
		chk("address bump", 8'h11, v);
		$display("operation test done");
	endtask

	task automatic t_relock;
		wr(iap_pkg::ADDR_CTRL, 8'h00);
		repeat (2) @(posedge clk);
		#1 chk("relocked", 1'b0, writeEnabled);
		op(8'h94, 1'b0, 16'h0000, 1'b1, 1'b0);
		$display("relock test done");
	endtask

	task automatic conclude;
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	// whole sequence needs about 7200 cycles
	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		conclude();
	end

	initial begin
		rstn = 1'b0;
		bus = '0;
		opDone = 1'b0;
		repeat (3) @(posedge clk);
		rstn <= 1'b1;
		@(posedge clk);
		t_regs();
		t_locked();
		t_unlockFail();
		t_unlock();
		t_ops();
		t_relock();
		conclude();
	end
endmodule // testbench
